// ===== include/ahp_pkg.sv
// constants, field layout and types of the converter host port
// assumes one 20 MHz clock drives the whole block
package ahp_pkg;

	////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int CW_W    = 10;
	localparam int DATA_W  = 10;
	localparam int CHAN_W  = 3;
	localparam int CNT_W   = 5;
	// three strobes plus the data port pass the pin synchroniser together
	localparam int SYNC_W  = 3 + DATA_W;

	////////////////////////////////////////////////////////////////////////////
	// control word field positions
	localparam int CW_CHAN_A_LSB  = 0;
	localparam int CW_CHAN_B_LSB  = 3;
	localparam int CW_DUAL_POS    = 6;
	localparam int CW_HALF_POS    = 7;
	localparam int CW_PDOWN_POS   = 8;
	localparam int CW_FLAG_POS    = 9;

	// reset values
	localparam logic [CW_W-1:0]   CW_RESET   = 10'h000;
	localparam logic [DATA_W-1:0] RES_RESET  = 10'h000;

	////////////////////////////////////////////////////////////////////////////
	// timing: clock rate in MHz, then durations in clock cycles of the conversion clock
	localparam real CLK_MHZ          = 20.0;
	localparam real ACQ_CLKS_MIN     = 4.5;
	localparam real ACQ_CLKS_MAX     = 5.5;
	// acquisition window sits inside 4.5 to 5.5: least whole count above the minimum
	localparam logic [CNT_W-1:0] ACQ_CYCLES  = CNT_W'($ceil(ACQ_CLKS_MIN));
	localparam logic [CNT_W-1:0] CONV_CYCLES = 5'h0E;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic              flag_behaviour_bit;
		logic              powerdown_bit;
		logic              half_scale_bit;
		logic              dual_sample_bit;
		logic [CHAN_W-1:0] chan_second;
		logic [CHAN_W-1:0] chan_first;
	} ahp_ctrl_t;

	typedef struct packed {
		logic              cs_n;
		logic              rd_n;
		logic              wr_n;
		logic [DATA_W-1:0] data;
	} ahp_pins_t;

	// gray codes along idle, acquire, first, second
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ACQ   = 3'h1,
		ST_CONV1 = 3'h3,
		ST_CONV2 = 3'h2,
		ST_PDOWN = 3'h6
	} ahp_state_t;

endpackage

// ===== rtl/ahp_sync.sv
// two-stage synchroniser for the host port pins
// assumes pins are asynchronous to CLK; only stage two is read outside
module ahp_sync
	import ahp_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RESET,
	input  wire logic [SYNC_W-1:0] d,
	output logic      [SYNC_W-1:0] q
);

	logic [SYNC_W-1:0] meta_q;

	////////////////////////////////////////////////////////////////////////////
	// idle pins are high, so the chain resets to all ones
	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++) begin : g_bit
			always_ff @(posedge CLK) begin
				if (RESET) begin
					meta_q[i] <= 1'b1;
					q[i]      <= 1'b1;
				end else begin
					meta_q[i] <= d[i];
					q[i]      <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

// ===== rtl/ahp_timer.sv
// down counter for acquisition and conversion phases
// assumes load and clear come from logic on CLK
module ahp_timer
	import ahp_pkg::*;
(
	input  wire logic             CLK,
	input  wire logic             RESET,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] count,
	input  wire logic             clear,
	output logic                  done
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             running;

	////////////////////////////////////////////////////////////////////////////
	assign running = (cnt_q != '0);
	// load stays out of done: the caller builds load from done
	assign done    = (cnt_q == CNT_W'(1)) && !clear;
	assign cnt_d   = clear   ? '0 :
	                 load    ? count :
	                 running ? cnt_q - CNT_W'(1) : cnt_q;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

// ===== rtl/ahp_top.sv
// conversion sequencer and parallel host port of a 10-bit converter
// assumes strobes and data pins are asynchronous; CONV_RESULT is valid on CLK
//
// Functional notes
// - writing power-down one abandons any conversion underway
// - a write during conversion forces the flag high at the strobe's leading edge
// - strobes and chip select keep working while powered down
// - result registers survive power-down when idle and read as usual
// - leaving power-down starts one or two conversions automatically
// - that automatic conversion overwrites the result registers with its results
// - writing power-down zero resumes normal operation
// - other control fields persist through power-down; exit write reloads all
// - the flag is driven high throughout power-down
// - chip select high puts the data port in high impedance
// - write strobe rising with chip select low loads control and starts
// - single mode reads always return the first result
// - dual mode reads alternate first and second, starting with first
// - a read during conversion stops it and returns unreliable data
// - a write during conversion halts it, resamples and restarts the sequence
// - each conversion lasts 14 clock cycles
// - acquisition lasts 4.5 to 5.5 cycles after write strobe rises
// - control word clears to zero at reset
// - dual bit selects one channel or two sampled together
// - in dual mode the flag stays put between the two conversions
// - flag bit picks low during conversion or low after completion
module ahp_top
	import ahp_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RESET,
	input  wire logic              CS_N,
	input  wire logic              RD_N,
	input  wire logic              WR_N,
	input  wire logic [DATA_W-1:0] DATA_IN,
	output logic      [DATA_W-1:0] DATA_OUT,
	output logic                   DATA_OE,
	output logic                   BUSY_INT_N,
	input  wire logic [DATA_W-1:0] CONV_RESULT,
	output logic      [CHAN_W-1:0] CHAN_FIRST,
	output logic      [CHAN_W-1:0] CHAN_SECOND,
	output logic                   CONV_SLOT,
	output logic                   TRACK_HOLD,
	output logic                   HALF_SCALE,
	output logic                   POWER_DOWN
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchroniser and edge detect
	ahp_pins_t pins_raw;
	ahp_pins_t pins_s;
	logic      cs_prev_q;
	logic      rd_prev_q;
	logic      wr_prev_q;

	assign pins_raw = '{cs_n: CS_N, rd_n: RD_N, wr_n: WR_N, data: DATA_IN};

	ahp_sync u_sync (
		.CLK   (CLK),
		.RESET (RESET),
		.d     (pins_raw),
		.q     (pins_s)
	);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			cs_prev_q <= 1'b1;
			rd_prev_q <= 1'b1;
			wr_prev_q <= 1'b1;
		end else begin
			cs_prev_q <= pins_s.cs_n;
			rd_prev_q <= pins_s.rd_n;
			wr_prev_q <= pins_s.wr_n;
		end
	end

	// edges are taken on the synchronised copies only
	logic selected;
	logic wr_fall;
	logic wr_rise;
	logic rd_fall;
	logic rd_rise;

	assign selected = !pins_s.cs_n;
	assign wr_fall  = selected && pins_s.rd_n && !pins_s.wr_n && wr_prev_q;
	assign wr_rise  = selected && pins_s.rd_n && pins_s.wr_n && !wr_prev_q;
	assign rd_fall  = selected && pins_s.wr_n && !pins_s.rd_n && rd_prev_q;
	assign rd_rise  = selected && pins_s.wr_n && pins_s.rd_n && !rd_prev_q;

	////////////////////////////////////////////////////////////////////////////
	// control word
	ahp_ctrl_t ctrl_q;
	ahp_ctrl_t ctrl_d;
	ahp_ctrl_t ctrl_new;

	assign ctrl_new = ahp_ctrl_t'(pins_s.data);
	// strobes stay live in power-down, so the exit write reloads all fields
	assign ctrl_d   = wr_rise ? ctrl_new : ctrl_q;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			ctrl_q <= ahp_ctrl_t'(CW_RESET);
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer
	ahp_state_t state_q;
	ahp_state_t state_d;
	logic       timer_done;
	logic       timer_load;
	logic       timer_clear;
	logic [CNT_W-1:0] timer_count;

	logic converting;
	logic abort;
	logic enter_pdown;
	logic leave_pdown;
	logic start_seq;
	logic store_first;
	logic store_second;
	logic seq_done;
	logic in_acq;
	logic in_conv1;
	logic in_conv2;
	logic in_pdown;

	assign in_acq      = (state_q == ST_ACQ);
	assign in_conv1    = (state_q == ST_CONV1);
	assign in_conv2    = (state_q == ST_CONV2);
	assign in_pdown    = (state_q == ST_PDOWN);
	assign converting  = in_acq || in_conv1 || in_conv2;
	// a read or a write leading edge kills the conversion at once
	assign abort       = converting && (wr_fall || rd_fall);
	assign enter_pdown = wr_rise && ctrl_new.powerdown_bit;
	assign leave_pdown = wr_rise && !ctrl_new.powerdown_bit
	                     && in_pdown;
	// every non power-down write resamples and restarts
	assign start_seq   = wr_rise && !ctrl_new.powerdown_bit;
	// a restart on the finishing edge wins, so nothing is stored then
	assign store_first  = in_conv1 && timer_done && !abort && !start_seq;
	assign store_second = in_conv2 && timer_done && !abort && !start_seq;
	assign seq_done     = (store_first && !ctrl_q.dual_sample_bit)
	                      || store_second;

	assign timer_clear = abort || enter_pdown;
	assign timer_load  = start_seq || (timer_done && in_acq)
	                     || (store_first && ctrl_q.dual_sample_bit);
	assign timer_count = start_seq ? ACQ_CYCLES : CONV_CYCLES;

	ahp_timer u_timer (
		.CLK   (CLK),
		.RESET (RESET),
		.load  (timer_load),
		.count (timer_count),
		.clear (timer_clear),
		.done  (timer_done)
	);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (enter_pdown) begin
					state_d = ST_PDOWN;
				end else if (start_seq) begin
					state_d = ST_ACQ;
				end
			end
			ST_ACQ: begin
				if (enter_pdown) begin
					state_d = ST_PDOWN;
				end else if (start_seq) begin
					state_d = ST_ACQ;
				end else if (abort) begin
					state_d = ST_IDLE;
				end else if (timer_done) begin
					state_d = ST_CONV1;
				end
			end
			ST_CONV1: begin
				if (enter_pdown) begin
					state_d = ST_PDOWN;
				end else if (start_seq) begin
					state_d = ST_ACQ;
				end else if (abort) begin
					state_d = ST_IDLE;
				end else if (timer_done) begin
					// second conversion follows on its own
					state_d = ctrl_q.dual_sample_bit ? ST_CONV2 : ST_IDLE;
				end
			end
			ST_CONV2: begin
				if (enter_pdown) begin
					state_d = ST_PDOWN;
				end else if (start_seq) begin
					state_d = ST_ACQ;
				end else if (abort || timer_done) begin
					state_d = ST_IDLE;
				end
			end
			ST_PDOWN: begin
				if (leave_pdown) begin
					state_d = ST_ACQ;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// result registers
	logic [DATA_W-1:0] first_result_reg_q;
	logic [DATA_W-1:0] second_result_reg_q;

	// no write path in power-down, so idle results are kept
	always_ff @(posedge CLK) begin
		if (RESET) begin
			first_result_reg_q  <= RES_RESET;
			second_result_reg_q <= RES_RESET;
		end else begin
			if (store_first) begin
				first_result_reg_q <= CONV_RESULT;
			end
			if (store_second) begin
				second_result_reg_q <= CONV_RESULT;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port
	logic              rd_second_q;
	logic              rd_second_d;
	logic [DATA_W-1:0] data_out_q;
	logic [DATA_W-1:0] read_word;

	// pointer restarts at first on every control write
	assign rd_second_d = wr_rise ? 1'b0 :
	                     rd_rise ? (ctrl_q.dual_sample_bit && !rd_second_q) :
	                     rd_second_q;
	// an aborted conversion leaves stale words, which is what the host gets
	assign read_word   = (ctrl_q.dual_sample_bit && rd_second_q) ?
	                     second_result_reg_q : first_result_reg_q;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rd_second_q <= 1'b0;
			data_out_q  <= RES_RESET;
		end else begin
			rd_second_q <= rd_second_d;
			if (rd_fall) begin
				data_out_q <= read_word;
			end
		end
	end

	// drive only while selected and reading
	assign DATA_OE  = selected && !pins_s.rd_n && pins_s.wr_n;
	assign DATA_OUT = data_out_q;

	////////////////////////////////////////////////////////////////////////////
	// conversion flag
	logic busy_n_q;
	logic busy_n_d;

	always_comb begin
		busy_n_d = busy_n_q;
		if (state_d == ST_PDOWN) begin
			busy_n_d = 1'b1;
		end else if (seq_done) begin
			busy_n_d = !ctrl_q.flag_behaviour_bit;
		end else if (start_seq) begin
			busy_n_d = ctrl_new.flag_behaviour_bit;
		end else if (wr_fall || rd_fall) begin
			// leading edge releases the flag, ending a conversion or interrupt
			busy_n_d = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			busy_n_q <= 1'b1;
		end else begin
			busy_n_q <= busy_n_d;
		end
	end

	assign BUSY_INT_N = busy_n_q;

	////////////////////////////////////////////////////////////////////////////
	// front-end controls
	assign CHAN_FIRST  = ctrl_q.chan_first;
	assign CHAN_SECOND = ctrl_q.chan_second;
	assign CONV_SLOT   = in_conv2;
	assign TRACK_HOLD  = in_conv1 || in_conv2;
	assign HALF_SCALE  = ctrl_q.half_scale_bit;
	assign POWER_DOWN  = in_pdown;

endmodule

// ===== tb/ahp_top_checker.sv
// port-level assertions for the host port sequencer
// assumes it is bound to ahp_top and sees only that module's ports
module ahp_top_checker
	import ahp_pkg::*;
(
	input wire logic              CLK,
	input wire logic              RESET,
	input wire logic              CS_N,
	input wire logic              RD_N,
	input wire logic              WR_N,
	input wire logic [DATA_W-1:0] DATA_IN,
	input wire logic [DATA_W-1:0] DATA_OUT,
	input wire logic              DATA_OE,
	input wire logic              BUSY_INT_N,
	input wire logic [DATA_W-1:0] CONV_RESULT,
	input wire logic [CHAN_W-1:0] CHAN_FIRST,
	input wire logic [CHAN_W-1:0] CHAN_SECOND,
	input wire logic              CONV_SLOT,
	input wire logic              TRACK_HOLD,
	input wire logic              HALF_SCALE,
	input wire logic              POWER_DOWN
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////
	// cycles spent in the current conversion slot
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             slot_q;
	assign cnt_d = !TRACK_HOLD ? 5'h00 : (CONV_SLOT != slot_q) ? 5'h01 : cnt_q + 5'h01;
	always_ff @(posedge CLK) begin
		cnt_q  <= RESET ? 5'h00 : cnt_d;
		slot_q <= RESET ? 1'b0 : CONV_SLOT;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	////////////////////////////////////////////////////////////
	a_conv_length: assert property (cnt_q <= CONV_CYCLES)
		else $error("conversion too long");
	// guard skips the flag-bit-one fall at completion
	a_acq_length: assert property ($fell(BUSY_INT_N) && !$past(TRACK_HOLD) &&
		!$past(TRACK_HOLD, 2) |-> ##1 !TRACK_HOLD[*4] ##1 TRACK_HOLD)
		else $error("acquisition length wrong");
	// second slot only opens after a first conversion ran to its end
	a_conv_exact: assert property ($rose(CONV_SLOT) |-> cnt_q == CONV_CYCLES)
		else $error("first conversion length wrong");
	a_slot_flag: assert property ($rose(CONV_SLOT) |-> $stable(BUSY_INT_N))
		else $error("flag moved between conversions");
	a_pdown_flag: assert property (POWER_DOWN |-> BUSY_INT_N)
		else $error("flag low in power down");
	a_pdown_idle: assert property (POWER_DOWN |-> !TRACK_HOLD && !CONV_SLOT)
		else $error("converting in power down");
	a_cs_float: assert property ($past(CS_N, 2) |-> !DATA_OE)
		else $error("port driven while deselected");
	a_read_abort: assert property ($fell(RD_N) && !CS_N && WR_N && TRACK_HOLD
		|-> ##[1:5] !TRACK_HOLD)
		else $error("read did not stop conversion");
	a_write_abort: assert property ($fell(WR_N) && !CS_N && RD_N && TRACK_HOLD
		|-> ##[1:5] BUSY_INT_N && !TRACK_HOLD)
		else $error("write did not halt conversion");
	c_dual: cover property ($rose(CONV_SLOT));
	c_pdown: cover property ($rose(POWER_DOWN));
	c_rd_abort: cover property ($fell(RD_N) && !CS_N && TRACK_HOLD);
endmodule
bind ahp_top ahp_top_checker u_ahp_top_checker (
	.CLK         (CLK),
	.RESET       (RESET),
	.CS_N        (CS_N),
	.RD_N        (RD_N),
	.WR_N        (WR_N),
	.DATA_IN     (DATA_IN),
	.DATA_OUT    (DATA_OUT),
	.DATA_OE     (DATA_OE),
	.BUSY_INT_N  (BUSY_INT_N),
	.CONV_RESULT (CONV_RESULT),
	.CHAN_FIRST  (CHAN_FIRST),
	.CHAN_SECOND (CHAN_SECOND),
	.CONV_SLOT   (CONV_SLOT),
	.TRACK_HOLD  (TRACK_HOLD),
	.HALF_SCALE  (HALF_SCALE),
	.POWER_DOWN  (POWER_DOWN)
);

// ===== tb/ahp_host.sv
// host bus model: strobes and data port of a parallel processor bus
// assumes the bench calls wr and rd; pins move on falling CLK
module ahp_host
	import ahp_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic [DATA_W-1:0] DATA_OUT,
	input  wire logic              DATA_OE,
	output logic                   CS_N,
	output logic                   RD_N,
	output logic                   WR_N,
	output logic      [DATA_W-1:0] DATA_IN
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		CS_N    = 1'b1;
		RD_N    = 1'b1;
		WR_N    = 1'b1;
		DATA_IN = 10'h3FF;
	end
	////////////////////////////////////////////////////////////
	// strobes held four cycles each side to clear the synchroniser
	task automatic wr(input logic [DATA_W-1:0] val);
		@(negedge CLK);
		CS_N    = 1'b0;
		DATA_IN = val;
		WR_N    = 1'b0;
		repeat (4) @(negedge CLK);
		WR_N = 1'b1;
		repeat (4) @(negedge CLK);
		CS_N    = 1'b1;
		DATA_IN = ~val; // released port shows no stale value
	endtask
	task automatic rd(output logic [DATA_W-1:0] val, output logic oe);
		@(negedge CLK);
		CS_N = 1'b0;
		RD_N = 1'b0;
		repeat (4) @(negedge CLK);
		val  = DATA_OUT;
		oe   = DATA_OE;
		RD_N = 1'b1;
		repeat (4) @(negedge CLK);
		CS_N = 1'b1;
	endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the converter host port sequencer
// assumes ahp_host as bus partner and the checker bound to ahp_top
module tb_top
	import ahp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [DATA_W-1:0] cw;
		logic [DATA_W-1:0] ra;
		logic [DATA_W-1:0] rb;
		logic [DATA_W-1:0] e2;
	} ahp_row_t;
	logic              CLK;
	logic              RESET;
	logic              CS_N, RD_N, WR_N, DATA_OE, BUSY_INT_N;
	logic              CONV_SLOT, TRACK_HOLD, HALF_SCALE, POWER_DOWN;
	logic [DATA_W-1:0] DATA_IN, DATA_OUT, CONV_RESULT;
	logic [CHAN_W-1:0] CHAN_FIRST, CHAN_SECOND;
	logic [DATA_W-1:0] ra, rb, v;
	logic              oe;
	int                num_errors = 0;
	int                n_compared = 0;
	int                cyc = 0;
	ahp_row_t          rows [4];
	ahp_top u_ahp_top (
		.CLK         (CLK),
		.RESET       (RESET),
		.CS_N        (CS_N),
		.RD_N        (RD_N),
		.WR_N        (WR_N),
		.DATA_IN     (DATA_IN),
		.DATA_OUT    (DATA_OUT),
		.DATA_OE     (DATA_OE),
		.BUSY_INT_N  (BUSY_INT_N),
		.CONV_RESULT (CONV_RESULT),
		.CHAN_FIRST  (CHAN_FIRST),
		.CHAN_SECOND (CHAN_SECOND),
		.CONV_SLOT   (CONV_SLOT),
		.TRACK_HOLD  (TRACK_HOLD),
		.HALF_SCALE  (HALF_SCALE),
		.POWER_DOWN  (POWER_DOWN)
	);
	ahp_host u_ahp_host (
		.CLK      (CLK),
		.DATA_OUT (DATA_OUT),
		.DATA_OE  (DATA_OE),
		.CS_N     (CS_N),
		.RD_N     (RD_N),
		.WR_N     (WR_N),
		.DATA_IN  (DATA_IN)
	);
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	// converter core stand-in: second slot gives a different code
	always @(negedge CLK) CONV_RESULT <= CONV_SLOT ? rb : ra;
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, string m);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic done_wait(input logic flag);
		for (int i = 0; i < 80 && BUSY_INT_N !== !flag; i++) @(negedge CLK);
		chk(10'(BUSY_INT_N), 10'(!flag), "flag at end");
	endtask
	task automatic rd_chk(input logic [DATA_W-1:0] exp);
		u_ahp_host.rd(v, oe);
		chk(10'(oe), 10'h001, "port enable");
		chk(v, exp, "read data");
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		rows = '{'{10'h005, 10'h155, 10'h2AA, 10'h155}, '{10'h05A, 10'h0F0, 10'h30F, 10'h30F},
			'{10'h2C7, 10'h2B4, 10'h14B, 10'h14B}, '{10'h238, 10'h3C3, 10'h03C, 10'h3C3}};
		RESET = 1'b1;
		ra = 10'h000;
		rb = 10'h000;
		repeat (16) @(negedge CLK);
		RESET = 1'b0;
		@(negedge CLK);
		chk(10'({DATA_OE, POWER_DOWN, HALF_SCALE, TRACK_HOLD}), 10'h000, "reset");
		chk(10'({BUSY_INT_N, CHAN_SECOND, CHAN_FIRST}), 10'h040, "reset ctrl");
		$display("test reset done");
		foreach (rows[k]) begin
			ra = rows[k].ra;
			rb = rows[k].rb;
			u_ahp_host.wr(rows[k].cw);
			chk(10'(BUSY_INT_N), 10'(rows[k].cw[CW_FLAG_POS]), "busy level");
			chk(10'({HALF_SCALE, CHAN_SECOND, CHAN_FIRST}),
				10'({rows[k].cw[7], rows[k].cw[5:0]}), "fields");
			done_wait(rows[k].cw[CW_FLAG_POS]);
			rd_chk(rows[k].ra);
			rd_chk(rows[k].e2);
			rd_chk(rows[k].ra);
			$display("test row %0d done", k);
		end
		ra = 10'h111;
		rb = 10'h222;
		u_ahp_host.wr(10'h05A);
		done_wait(1'b0);
		u_ahp_host.wr(10'h15A);
		chk(10'({POWER_DOWN, BUSY_INT_N, CHAN_SECOND}), 10'h01B, "power down");
		rd_chk(10'h111);
		rd_chk(10'h222);
		ra = 10'h333;
		rb = 10'h044;
		u_ahp_host.wr(10'h05A);
		chk(10'(POWER_DOWN), 10'h000, "wake");
		done_wait(1'b0);
		rd_chk(10'h333);
		rd_chk(10'h044);
		$display("test power down done");
		u_ahp_host.wr(10'h000);
		// wait into the first conversion so the write really abandons it
		repeat (4) @(negedge CLK);
		u_ahp_host.wr(10'h100);
		chk(10'({POWER_DOWN, TRACK_HOLD, BUSY_INT_N}), 10'h005, "abandon");
		ra = 10'h0AB;
		u_ahp_host.wr(10'h000);
		done_wait(1'b0);
		rd_chk(10'h0AB);
		$display("test power down mid conversion done");
		u_ahp_host.wr(10'h001);
		repeat (4) @(negedge CLK);
		u_ahp_host.rd(v, oe);
		chk(10'({TRACK_HOLD, BUSY_INT_N}), 10'h001, "read abort");
		$display("test read abort done");
		ra = 10'h1C7;
		u_ahp_host.wr(10'h002);
		repeat (4) @(negedge CLK);
		u_ahp_host.wr(10'h003);
		chk(10'({BUSY_INT_N, CHAN_FIRST}), 10'h003, "restart");
		done_wait(1'b0);
		rd_chk(10'h1C7);
		$display("test write restart done");
		u_ahp_host.wr(10'h0BF);
		RESET = 1'b1;
		repeat (16) @(negedge CLK);
		RESET = 1'b0;
		@(negedge CLK);
		chk(10'({HALF_SCALE, CHAN_SECOND, CHAN_FIRST}), 10'h000, "mid reset ctrl");
		chk(10'({BUSY_INT_N, TRACK_HOLD, DATA_OUT[0]}), 10'h004, "mid reset state");
		$display("test mid reset done");
		close_out();
	end
endmodule
